// ===== rtl/hie_map.svh
// offsets, field codes and constants for the host indication encoder
`ifndef HIE_MAP_SVH
`define HIE_MAP_SVH
`define HIE_REG_CTRL        12'h000
`define HIE_REG_CMD         12'h004
`define HIE_REG_STATUS      12'h008
`define HIE_REG_ADDR        12'h00c
`define HIE_REG_FRAME       12'h010
`define HIE_REG_HEALTH      12'h014
`define HIE_CMD_RESET       8'h01
`define HIE_CMD_STATE       8'h02
`define HIE_CMD_SET_BUSY    8'h03
`define HIE_CMD_QUIT_BUSY   8'h04
`define HIE_CMD_BUSMON      8'h05
`define HIE_CMD_SYS_STAT    8'h0d
`define HIE_CMD_CONFIG      8'h18
`define HIE_CMD_ACKN        8'h10
`define HIE_CMD_SET_ADDR    8'hf1
`define HIE_CON_LOW         7'h0b
`define HIE_RESET_IND       8'h03
`define HIE_STATE_LOW       3'h7
`define HIE_FERR_LOW        3'h3
`define HIE_CFG_LOW         2'h1
`define HIE_HEALTH_IND      8'h4b
`define HIE_FEND_IND        8'hcb
`define HIE_STOP_IND        8'h2b
`define HIE_MODE_NORMAL     2'h3
`define HIE_ACK_BUSY        8'hc0
`define HIE_ACK_POS         8'hcc
`endif

// ===== rtl/hie_pkg.sv
// types of the host indication encoder
package hie_pkg;
   typedef enum logic [3:0]
   {
      HIE_IDLE  = 4'b0001,
      HIE_FRAME = 4'b0010,
      HIE_ONE   = 4'b0100,
      HIE_TWO   = 4'b1000
   } hie_state_t;
   typedef enum logic [1:0]
   {
      HIE_SRC_NONE  = 2'h0,
      HIE_SRC_LOCAL = 2'h1
   } hie_src_t;
endpackage

// ===== rtl/hie_sticky.sv
// sticky flag where a set wins over a clear
`timescale 1ns/10ps
`default_nettype none
module hie_sticky
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control
   input  wire logic set_i,
   input  wire logic clr_i,
   // state
   output logic      flag_q
);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_q <= 1'b0;
      else if (set_i)
         flag_q <= 1'b1;
      else if (clr_i)
         flag_q <= 1'b0;
   end
endmodule
`default_nettype wire

// ===== rtl/hie_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module hie_sync
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // level
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= 1'b0;
         q_o    <= 1'b0;
      end
      else
      begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/hie_top.sv
// host indication encoder: bus frame forwarding and local indications
`include "hie_map.svh"
`timescale 1ns/10ps
`default_nettype none
//
// Operation
// RULE1: received bus bytes go to the host unchanged.
// RULE2: acknowledge bytes forwarded only in bus-monitor mode.
// RULE3: data control byte: std bit7, r bit5, bit4 one, priority 3:2.
// RULE4: confirmation byte: result bit 7, low bits 0001011.
// RULE5: acknowledge byte copies frame, bits 5,4,1,0 forced zero.
// RULE6: state byte: collision, rx, tx, protocol, thermal, then 111.
// RULE7: collision while sending polling state sets collision flag.
// RULE8: corrupted host bytes set the receive-error flag.
// RULE9: dominant sent but recessive seen sets transmit-error flag.
// RULE10: bad command order from host sets protocol-error flag.
// RULE11: thermal flag follows the thermal warning condition.
// RULE12: frame-error byte: three error bits, one, reserved, 011.
// RULE13: configuration byte: 0, reserved, aa ap crc frame_end_tag, 01.
// RULE14: reset request reinitialises; reset indication sent on normal state.
// RULE15: busy plus auto-ack answers own-address frames with busy acknowledge.
// RULE16: set-busy has no acknowledge effect without auto-ack.
// RULE17: host acknowledge request leaves busy mode at once.
// RULE18: quit-busy restores positive acknowledge when auto-ack active.
// RULE19: quit-busy changes nothing without auto-ack or busy.
// RULE20: only set-address enables auto-ack and stores the address.
// RULE21: health second byte low bits give operating mode.
// RULE22: no local byte is inserted inside a forwarded frame.
module hie_top
(
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // bus receive side
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_is_ack,
   input  wire logic        rx_frame_last,
   input  wire logic        rx_dest_match,
   input  wire logic        rx_header,
   input  wire logic        rx_extended,
   input  wire logic        rx_repeated,
   input  wire logic [1:0]  rx_priority,
   // bus events
   input  wire logic        poll_collision,
   input  wire logic        host_byte_corrupt,
   input  wire logic        bus_bit_mismatch,
   input  wire logic        cmd_order_bad,
   input  wire logic        thermal_pin,
   input  wire logic        tx_done,
   input  wire logic        tx_positive,
   input  wire logic [1:0]  op_mode,
   input  wire logic [5:0]  health_bits,
   // host byte stream
   output logic             host_valid,
   output logic      [7:0]  host_byte,
   input  wire logic        host_ready,
   // bus acknowledge request
   output logic             ack_valid,
   output logic      [7:0]  ack_byte
);
   import hie_pkg::*;

   hie_state_t  state_q;
   logic        wr;
   logic        rd;
   logic [7:0]  cmd;
   logic        cmd_wr;
   logic        thermal_s;
   logic        busmon_q;
   logic        busy_q;
   logic        auto_ack_active_flag;
   logic        auto_poll_active_flag;
   logic        crc_q;
   logic        frame_end_tag;
   logic [15:0] phys_addr_q;
   logic        rst_pend_q;
   logic        con_pend_q;
   logic        con_pos_q;
   logic        state_pend_q;
   logic        cfg_pend_q;
   logic        sys_pend_q;
   logic [1:0]  mode_q;
   logic        polling_collision_flag;
   logic        host_rx_error_flag;
   logic        bus_tx_error_flag;
   logic        cmd_sequence_error_flag;
   logic        thermal_warn_flag;
   logic        state_clr;
   logic [7:0]  second_q;
   logic        fwd;
   logic [7:0]  fwd_byte;
   logic        in_frame_q;
   logic [7:0]  frame_error_indication;
   logic [7:0]  system_health_indication;
   logic [2:0]  ferr_q;

   assign wr      = psel && penable && pwrite;
   assign rd      = psel && penable && !pwrite;
   assign pready  = 1'b1;
   assign cmd_wr  = wr && (paddr == `HIE_REG_CMD);
   assign cmd     = pwdata[7:0];

   hie_sync u_thermal
   (
      .pclk    (pclk),
      .presetn (presetn),
      .d_i     (thermal_pin),
      .q_o     (thermal_s)
   );

   // collision and error flags of the state byte latch until the state indication goes out; thermal is not latched
   // only the state byte ends in 111 among local bytes sent from HIE_ONE, so its hand-over is the clear
   assign state_clr = (state_q == HIE_ONE) && host_ready && (host_byte[2:0] == `HIE_STATE_LOW);
   hie_sticky u_sc
   (
      .pclk(pclk), .presetn(presetn), .set_i(poll_collision), // see RULE7
      .clr_i(state_clr), .flag_q(polling_collision_flag)
   );
   hie_sticky u_re
   (
      .pclk(pclk), .presetn(presetn), .set_i(host_byte_corrupt), // see RULE8
      .clr_i(state_clr), .flag_q(host_rx_error_flag)
   );
   hie_sticky u_te
   (
      .pclk(pclk), .presetn(presetn), .set_i(bus_bit_mismatch), // see RULE9
      .clr_i(state_clr), .flag_q(bus_tx_error_flag)
   );
   hie_sticky u_pe
   (
      .pclk(pclk), .presetn(presetn), .set_i(cmd_order_bad), // see RULE10
      .clr_i(state_clr), .flag_q(cmd_sequence_error_flag)
   );
   assign thermal_warn_flag = thermal_s; // see RULE11

   // mode and busy handling; reset request returns bus-monitor, busy, auto-ack, auto-poll, crc, frame_end_tag and address to initial state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busmon_q              <= 1'b0;
         busy_q                <= 1'b0;
         auto_ack_active_flag  <= 1'b0;
         auto_poll_active_flag <= 1'b0;
         crc_q                 <= 1'b0;
         frame_end_tag         <= 1'b0;
         phys_addr_q           <= 16'h0000;
      end
      else if (cmd_wr && cmd == `HIE_CMD_RESET)
      begin
         busmon_q              <= 1'b0; // see RULE14
         busy_q                <= 1'b0;
         auto_ack_active_flag  <= 1'b0;
         auto_poll_active_flag <= 1'b0;
         crc_q                 <= 1'b0;
         frame_end_tag         <= 1'b0;
         phys_addr_q           <= 16'h0000;
      end
      else if (cmd_wr)
      begin
         if (cmd == `HIE_CMD_BUSMON)
            busmon_q <= 1'b1;
         if (cmd == `HIE_CMD_SET_BUSY)
            busy_q <= 1'b1;
         if (cmd == `HIE_CMD_QUIT_BUSY)
            busy_q <= 1'b0; // see RULE18, RULE19
         if (cmd[7:3] == 5'h02)
            busy_q <= 1'b0; // see RULE17
         if (cmd[7:3] == 5'h03)
         begin
            auto_poll_active_flag <= cmd[2];
            crc_q                 <= cmd[1];
            frame_end_tag         <= cmd[0];
         end
         if (cmd == `HIE_CMD_SET_ADDR)
         begin
            auto_ack_active_flag <= 1'b1; // see RULE20
            phys_addr_q          <= pwdata[23:8];
         end
      end
   end

   // bus acknowledge: busy only counts with auto-ack
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack_valid <= 1'b0;
         ack_byte  <= 8'h00;
      end
      else
      begin
         ack_valid <= rx_valid && !rx_is_ack && rx_frame_last && rx_dest_match && auto_ack_active_flag;
         ack_byte  <= busy_q ? `HIE_ACK_BUSY : `HIE_ACK_POS; // see RULE15, RULE16
      end
   end

   // forwarding path; header byte rebuilt from frame fields
   always_comb
   begin
      fwd      = rx_valid && (!rx_is_ack || busmon_q); // see RULE2
      fwd_byte = rx_byte; // see RULE1
      if (rx_header)
         fwd_byte = {!rx_extended, 1'b0, !rx_repeated, 1'b1, rx_priority, 2'h0}; // see RULE3
      if (rx_is_ack)
         fwd_byte = {rx_byte[7:6], 2'h0, rx_byte[3:2], 2'h0}; // see RULE5
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         in_frame_q <= 1'b0;
      else if (fwd && !rx_is_ack)
         in_frame_q <= !rx_frame_last;
   end

   // pending local indications
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_pend_q   <= 1'b0;
         con_pend_q   <= 1'b0;
         con_pos_q    <= 1'b0;
         state_pend_q <= 1'b0;
         cfg_pend_q   <= 1'b0;
         sys_pend_q   <= 1'b0;
         mode_q       <= 2'h0;
         ferr_q       <= 3'h0;
      end
      else
      begin
         mode_q <= op_mode;
         if (op_mode == `HIE_MODE_NORMAL && mode_q != `HIE_MODE_NORMAL)
            rst_pend_q <= 1'b1; // see RULE14
         else if (state_q == HIE_ONE && host_ready && host_byte == `HIE_RESET_IND)
            rst_pend_q <= 1'b0;
         if (tx_done)
         begin
            con_pend_q <= 1'b1;
            con_pos_q  <= tx_positive;
         end
         else if (state_q == HIE_ONE && host_ready && host_byte[6:0] == `HIE_CON_LOW)
            con_pend_q <= 1'b0;
         if (cmd_wr && cmd == `HIE_CMD_STATE)
            state_pend_q <= 1'b1;
         else if (state_q == HIE_ONE && host_ready && host_byte[2:0] == `HIE_STATE_LOW)
            state_pend_q <= 1'b0;
         if (cmd_wr && (cmd == `HIE_CMD_SET_ADDR || cmd[7:3] == 5'h03))
            cfg_pend_q <= 1'b1;
         else if (state_q == HIE_ONE && host_ready && host_byte[1:0] == `HIE_CFG_LOW)
            cfg_pend_q <= 1'b0;
         if (cmd_wr && cmd == `HIE_CMD_SYS_STAT)
            sys_pend_q <= 1'b1;
         else if (state_q == HIE_TWO && host_ready)
            sys_pend_q <= 1'b0;
         if (wr && paddr == `HIE_REG_FRAME)
            ferr_q <= pwdata[2:0];
      end
   end

   assign frame_error_indication   = {ferr_q, 1'b1, 1'b0, `HIE_FERR_LOW}; // see RULE12
   assign system_health_indication = `HIE_HEALTH_IND;

   // output sequencer: frame bytes have priority and are never split
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q    <= HIE_IDLE;
         host_valid <= 1'b0;
         host_byte  <= 8'h00;
         second_q   <= 8'h00;
      end
      else
      begin
         case (state_q)
            HIE_IDLE, HIE_FRAME:
            begin
               if (fwd)
               begin
                  host_valid <= 1'b1;
                  host_byte  <= fwd_byte;
                  state_q    <= HIE_FRAME;
               end
               else if (host_valid && !host_ready)
                  state_q <= state_q;
               else if (!in_frame_q && (rst_pend_q || con_pend_q || state_pend_q || cfg_pend_q
                        || sys_pend_q)) // see RULE22
               begin
                  host_valid <= 1'b1;
                  state_q    <= HIE_ONE;
                  if (rst_pend_q)
                     host_byte <= `HIE_RESET_IND;
                  else if (con_pend_q)
                     host_byte <= {con_pos_q, `HIE_CON_LOW}; // see RULE4
                  else if (state_pend_q)
                     host_byte <= {polling_collision_flag, host_rx_error_flag, bus_tx_error_flag,
                                   cmd_sequence_error_flag, thermal_warn_flag, `HIE_STATE_LOW}; // see RULE6
                  else if (cfg_pend_q)
                     host_byte <= {1'b0, 1'b0, auto_ack_active_flag, auto_poll_active_flag, crc_q,
                                   frame_end_tag, `HIE_CFG_LOW}; // see RULE13
                  else
                  begin
                     host_byte <= system_health_indication;
                     second_q  <= {health_bits, mode_q}; // see RULE21
                  end
               end
               else
               begin
                  host_valid <= 1'b0;
                  state_q    <= HIE_IDLE;
               end
            end
            HIE_ONE:
            begin
               if (host_ready && host_byte == `HIE_HEALTH_IND && sys_pend_q)
               begin
                  host_byte <= second_q;
                  state_q   <= HIE_TWO;
               end
               else if (host_ready)
               begin
                  host_valid <= 1'b0;
                  state_q    <= HIE_IDLE;
               end
            end
            HIE_TWO:
            begin
               if (host_ready)
               begin
                  host_valid <= 1'b0;
                  state_q    <= HIE_IDLE;
               end
            end
            default:
               state_q <= HIE_IDLE;
         endcase
      end
   end

   // register read mux
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (paddr == `HIE_REG_STATUS)
            prdata <= {24'h0, busmon_q, busy_q, auto_ack_active_flag, polling_collision_flag,
                       host_rx_error_flag, bus_tx_error_flag, cmd_sequence_error_flag, thermal_warn_flag};
         else if (paddr == `HIE_REG_ADDR)
            prdata <= {16'h0, phys_addr_q};
         else if (paddr == `HIE_REG_FRAME)
            prdata <= {24'h0, frame_error_indication};
         else if (paddr == `HIE_REG_CTRL || paddr == `HIE_REG_CMD || paddr == `HIE_REG_HEALTH)
            prdata <= 32'h0000_0000;
         else
            pslverr <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/hie_chk.sv
// port assertions for the host indication encoder
`timescale 1ns/10ps
`default_nettype none
module hie_chk
(
   // apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // bus side
   input wire logic        rx_valid,
   input wire logic [7:0]  rx_byte,
   input wire logic        rx_is_ack,
   input wire logic        tx_done,
   input wire logic        tx_positive,
   input wire logic [1:0]  op_mode,
   // host and acknowledge
   input wire logic        host_valid,
   input wire logic [7:0]  host_byte,
   input wire logic        host_ready,
   input wire logic        ack_valid,
   input wire logic [7:0]  ack_byte
);
   logic       cw;
   logic [7:0] rx_q;
   logic       z_q;
   assign cw = psel && penable && pwrite && paddr == 12'h004;
   // last byte and result seen, so later checks can compare
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         rx_q <= 8'h00;
      else if (rx_valid && !rx_is_ack)
         rx_q <= rx_byte;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         z_q <= 1'b0;
      else if (tx_done)
         z_q <= tx_positive;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   hold_taken_a:
   assert property (host_valid && !host_ready |=> host_valid && $stable(host_byte))
      else $error("host byte changed before taken");
   frame_fwd_a:
   assert property (rx_valid && !rx_is_ack |-> ##[1:7] host_valid && host_byte == rx_q)
      else $error("bus byte not forwarded");
   con_byte_a:
   assert property (tx_done |-> ##[1:60] host_valid && host_byte == {z_q, 7'h0b})
      else $error("confirmation byte missing");
   reset_ind_a:
   assert property (op_mode == 2'h3 && $past(op_mode) != 2'h3 |-> ##[1:30] host_valid && host_byte == 8'h03)
      else $error("reset indication missing");
   state_low_a:
   assert property (cw && pwdata[7:0] == 8'h02 |-> ##[1:20] host_valid && host_byte[2:0] == 3'h7)
      else $error("state byte missing");
   health_head_a:
   assert property (cw && pwdata[7:0] == 8'h0d |-> ##[1:20] host_valid && host_byte == 8'h4b)
      else $error("health head byte missing");
   cfg_after_addr_a:
   assert property (cw && pwdata[7:0] == 8'hf1 |-> ##[1:20] host_valid && host_byte[7:5] == 3'h1
                    && host_byte[1:0] == 2'h1)
      else $error("configuration byte missing");
   ack_codes_a:
   assert property (ack_valid |-> ack_byte == 8'hc0 || ack_byte == 8'hcc)
      else $error("bad acknowledge code");
   ack_single_a:
   assert property (ack_valid |=> !ack_valid)
      else $error("acknowledge longer than one cycle");
   apb_ready_a:
   assert property (psel && penable |-> pready)
      else $error("apb not ready");
endmodule
bind hie_top hie_chk chk_u
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .rx_valid, .rx_byte,
   .rx_is_ack, .tx_done, .tx_positive, .op_mode, .host_valid, .host_byte, .host_ready,
   .ack_valid, .ack_byte
);
`default_nettype wire

// ===== testbench/hie_host_mdl.sv
// host controller model taking indication bytes with random stalls
`timescale 1ns/10ps
`default_nettype none
module hie_host_mdl
(
   // clock
   input wire logic       pclk,
   // byte stream
   input wire logic       host_valid,
   input wire logic [7:0] host_byte,
   output var logic       host_ready,
   // bytes taken
   output var logic       got_valid,
   output var logic [7:0] got_byte
);
   integer seed = 9;
   initial host_ready = 1'b0;
   // stalls about one cycle in four, short enough to keep up with the bus
   always @(posedge pclk)
   begin
      got_valid <= host_valid && host_ready;
      got_byte <= host_byte;
      host_ready <= ($random(seed) & 3) != 0;
   end
endmodule
`default_nettype wire

// ===== testbench/host_indication_encoder_tb.sv
// self-checking bench for the host indication encoder
`timescale 1ns/10ps
`default_nettype none
`include "hie_map.svh"
module host_indication_encoder_tb;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, er, host_valid, host_ready, ack_valid, got_valid;
   logic        rx_valid = 0, rx_is_ack = 0, rx_frame_last = 0, rx_dest_match = 0;
   logic        rx_header = 0, rx_extended = 0, rx_repeated = 0, thermal_pin = 0;
   logic        tx_done = 0, tx_positive = 0;
   logic [1:0]  rx_priority = 0, op_mode = 0;
   logic [3:0]  ev = 0;
   logic [5:0]  health_bits = 0;
   logic [15:0] pa = 0;
   logic [7:0]  rx_byte = 0, host_byte, ack_byte, got_byte, ab, hq[$], aq[$];
   int          bad_count = 0, checked = 0, cyc = 0;
   integer      seed = 9;
   hie_top dut_u
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .rx_valid, .rx_byte, .rx_is_ack, .rx_frame_last, .rx_dest_match, .rx_header,
      .rx_extended, .rx_repeated, .rx_priority, .poll_collision(ev[3]),
      .host_byte_corrupt(ev[2]), .bus_bit_mismatch(ev[1]), .cmd_order_bad(ev[0]),
      .thermal_pin, .tx_done, .tx_positive, .op_mode, .health_bits,
      .host_valid, .host_byte, .host_ready, .ack_valid, .ack_byte
   );
   hie_host_mdl host_u
   (
      .pclk, .host_valid, .host_byte, .host_ready, .got_valid, .got_byte
   );
   always #2.5 pclk = ~pclk;
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task give_verdict;
      chk("pending notes", hq.size() + aq.size(), 0);
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task cmd(input logic [31:0] d);
      apb(1, 12'h004, d);
      repeat (12) @(posedge pclk);
   endtask
   // one bus frame; header byte already in data control form
   task frame(input logic dm, input logic [7:0] ak, input logic c);
      logic [7:0] b;
      int         n;
      n = 2 + ($random(seed) & 3);
      rx_extended <= $random(seed);
      rx_repeated <= $random(seed);
      rx_priority <= $random(seed);
      rx_dest_match <= dm;
      @(posedge pclk);
      for (int i = 0; i <= n; i++)
      begin
         b = i ? $random(seed) : {~rx_extended, 1'b0, ~rx_repeated, 1'b1, rx_priority, 2'b00};
         rx_valid <= 1;
         rx_byte <= b;
         rx_header <= i == 0;
         rx_frame_last <= i == n;
         tx_done <= c && i == 1;
         tx_positive <= 1;
         hq.push_back(b);
         if (i == n && c)
            hq.push_back(8'h8b);
         if (i == n && ak)
            aq.push_back(ak);
         @(posedge pclk);
         rx_valid <= 0;
         tx_done <= 0;
         repeat (7) @(posedge pclk);
      end
      repeat (12) @(posedge pclk);
   endtask
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (got_valid === 1'b1)
         chk("host byte", got_byte, hq.size() ? hq.pop_front() : 32'h100);
      if (ack_valid === 1'b1)
         chk("ack byte", ack_byte, aq.size() ? aq.pop_front() : 32'h100);
      if (cyc == 20000)
      begin
         bad_count++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (6) @(posedge pclk);
      chk("reset outputs", {host_valid, ack_valid, pready}, 3'b001);
      presetn <= 1;
      op_mode <= 2'h3;
      health_bits <= $random(seed);
      hq.push_back(`HIE_RESET_IND);
      repeat (30) @(posedge pclk);
      hq.push_back(8'h4b);
      hq.push_back({health_bits, 2'b11});
      cmd(`HIE_CMD_SYS_STAT);
      for (int z = 0; z < 2; z++)
      begin
         tx_positive <= z[0];
         tx_done <= 1;
         hq.push_back({z[0], 7'h0b});
         @(posedge pclk);
         tx_done <= 0;
         repeat (20) @(posedge pclk);
      end
      // each flag alone, then none, thermal first
      for (int k = 0; k < 6; k++)
      begin
         thermal_pin <= k == 0;
         ev <= (k > 0 && k < 5) ? 4'h1 << (k - 1) : 4'h0;
         @(posedge pclk);
         ev <= 0;
         repeat (6) @(posedge pclk);
         hq.push_back(k < 5 ? 8'h07 | 8'h08 << k : 8'h07);
         cmd(`HIE_CMD_STATE);
      end
      cmd(`HIE_CMD_SET_BUSY);
      frame(1, 0, 0);
      apb(0, `HIE_REG_STATUS, 0);
      chk("status", rd, 32'h0000_0040);
      hq.push_back(8'h21);
      pa = $random(seed);
      cmd({8'h00, pa, `HIE_CMD_SET_ADDR});
      apb(0, `HIE_REG_ADDR, 0);
      chk("phys addr", rd, {16'h0000, pa});
      cmd(`HIE_CMD_QUIT_BUSY);
      frame(1, `HIE_ACK_POS, 1);
      cmd(`HIE_CMD_SET_BUSY);
      frame(1, `HIE_ACK_BUSY, 0);
      frame(0, 0, 0);
      cmd(`HIE_CMD_ACKN);
      frame(1, `HIE_ACK_POS, 0);
      cmd(`HIE_CMD_QUIT_BUSY);
      frame(1, `HIE_ACK_POS, 0);
      cmd(`HIE_CMD_SET_BUSY);
      cmd(`HIE_CMD_QUIT_BUSY);
      frame(1, `HIE_ACK_POS, 0);
      apb(0, 12'h0f0, 0);
      chk("unmapped error", er, 1'b1);
      pa = $random(seed);
      apb(1, `HIE_REG_FRAME, {16'h0000, pa});
      apb(0, `HIE_REG_FRAME, 0);
      chk("frame error byte", rd, {24'h0, pa[2:0], 5'h13});
      op_mode <= 0;
      cmd(`HIE_CMD_RESET);
      op_mode <= 2'h3;
      hq.push_back(`HIE_RESET_IND);
      repeat (30) @(posedge pclk);
      hq.push_back(8'h15);
      cmd(`HIE_CMD_CONFIG | 8'h05);
      frame(1, 0, 0);
      for (int m = 0; m < 2; m++)
      begin
         if (m)
            cmd(`HIE_CMD_BUSMON);
         ab = $random(seed);
         if (m)
            hq.push_back(ab & 8'hcc);
         rx_is_ack <= 1;
         rx_valid <= 1;
         rx_byte <= ab;
         @(posedge pclk);
         rx_valid <= 0;
         rx_is_ack <= 0;
         repeat (20) @(posedge pclk);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
